// >>> hdl/obsc_loader.sv
// Start-up option loader: reads the option word after reset release, picks the clock
// source, runs the oscillator wait and routes the two oscillator pins.
// Assumes the option store answers with opt_data valid OBSC_READ_CYC cycles after release.
`timescale 1ns/1ps

module obsc_loader #(
    parameter int WAIT_SCALE = obsc_pkg::OBSC_WAIT_UNIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Option store
    input wire logic [obsc_pkg::OBSC_OPT_W-1:0] opt_data,
    output logic opt_read,
    // Start-up results
    output obsc_pkg::obsc_src_t clk_src,
    output obsc_pkg::obsc_pins_t pin_route,
    output logic cpu_reset_n,
    output logic opt_loaded
);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        OBSC_ST_READ = 2'h0,
        OBSC_ST_WAIT = 2'h1,
        OBSC_ST_RUN  = 2'h2
    } obsc_state_t;

    localparam obsc_pkg::obsc_pins_t PINS_PORT = '{pin_a_clock: 1'b0, pin_b_clock: 1'b0,
        port_a_en: 1'b1, port_b_en: 1'b1};
    localparam obsc_pkg::obsc_pins_t PINS_XTAL = '{pin_a_clock: 1'b1, pin_b_clock: 1'b1,
        port_a_en: 1'b0, port_b_en: 1'b0};
    localparam obsc_pkg::obsc_pins_t PINS_EXT = '{pin_a_clock: 1'b1, pin_b_clock: 1'b0,
        port_a_en: 1'b0, port_b_en: 1'b1};

    obsc_state_t state_reg;
    obsc_state_t state_next;
    logic [obsc_pkg::OBSC_CNT_W-1:0] cnt_reg;
    logic [obsc_pkg::OBSC_CNT_W-1:0] cnt_next;
    logic [obsc_pkg::OBSC_CNT_W-1:0] wait_last_dec;
    logic [obsc_pkg::OBSC_OPT_W-1:0] opt_reg;
    logic [1:0] clk_src_reg;
    obsc_pkg::obsc_src_t src_dec;
    obsc_pkg::obsc_pins_t pins_dec;
    logic [obsc_pkg::OBSC_WAIT_W-1:0] wait_sel;
    logic read_done;
    logic latch_en;
    logic wait_done;

    // ****************************************************************
    // Option decode
    // ****************************************************************
    assign src_dec = obsc_pkg::obsc_src_t'(opt_data[obsc_pkg::OBSC_SRC_LSB +: 2]);
    assign wait_sel = opt_reg[obsc_pkg::OBSC_WAIT_LSB +: obsc_pkg::OBSC_WAIT_W];
    assign read_done = (cnt_reg == obsc_pkg::OBSC_CNT_W'(obsc_pkg::OBSC_READ_CYC - 1));
    assign latch_en = (state_reg == OBSC_ST_READ) && read_done;

    // Wait length doubles per code step; code 0 still waits one unit
    assign wait_last_dec = obsc_pkg::OBSC_CNT_W'((WAIT_SCALE << wait_sel) - 1);
    assign wait_done = (cnt_reg == wait_last_dec);

    // Code 3 has no oscillator behind it, so its pins fall back to ports
    always_comb begin
        pins_dec = PINS_PORT;
        case (src_dec)
            obsc_pkg::OBSC_SRC_XTAL: begin
                pins_dec = PINS_XTAL;
            end
            obsc_pkg::OBSC_SRC_EXT: begin
                pins_dec = PINS_EXT;
            end
            default: begin
                pins_dec = PINS_PORT;
            end
        endcase
    end

    // ****************************************************************
    // State sequencing
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 1'b1;
        case (state_reg)
            OBSC_ST_READ: begin
                if (read_done) begin
                    cnt_next = '0;
                    if (src_dec == obsc_pkg::OBSC_SRC_XTAL) begin
                        state_next = OBSC_ST_WAIT;
                    end else begin
                        state_next = OBSC_ST_RUN;
                    end
                end
            end
            OBSC_ST_WAIT: begin
                if (wait_done) begin
                    state_next = OBSC_ST_RUN;
                end
            end
            OBSC_ST_RUN: begin
                cnt_next = cnt_reg;
            end
            default: begin
                state_next = OBSC_ST_READ;
                cnt_next = '0;
            end
        endcase
    end

    // Synchronous reset: a low pin anywhere before the read finishes restarts the read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= OBSC_ST_READ;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // ****************************************************************
    // Option latch
    // ****************************************************************
    // Captured only on the read step, so later pin noise cannot change the clock choice
    obsc_hold_reg #(
        .W(obsc_pkg::OBSC_OPT_W),
        .RST_VAL(obsc_pkg::OBSC_OPT_RST)
    ) i_opt_hold (
        .clk(ref_clk),
        .rst_n(rst_n),
        .load(latch_en),
        .d(opt_data),
        .q(opt_reg)
    );

    obsc_hold_reg #(
        .W(1),
        .RST_VAL(1'b0)
    ) i_loaded_hold (
        .clk(ref_clk),
        .rst_n(rst_n),
        .load(latch_en),
        .d(1'b1),
        .q(opt_loaded)
    );

    // ****************************************************************
    // Selection outputs
    // ****************************************************************
    // Until the option is loaded the pins stay as ports, the harmless default
    obsc_hold_reg #(
        .W(2),
        .RST_VAL(2'h0)
    ) i_src_hold (
        .clk(ref_clk),
        .rst_n(rst_n),
        .load(latch_en),
        .d(src_dec),
        .q(clk_src_reg)
    );

    assign clk_src = obsc_pkg::obsc_src_t'(clk_src_reg);

    obsc_hold_reg #(
        .W(4),
        .RST_VAL(PINS_PORT)
    ) i_pins_hold (
        .clk(ref_clk),
        .rst_n(rst_n),
        .load(latch_en),
        .d(pins_dec),
        .q(pin_route)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_reset_n <= 1'b0;
        end else begin
            cpu_reset_n <= (state_next == OBSC_ST_RUN);
        end
    end

    assign opt_read = (state_reg == OBSC_ST_READ) && rst_n;

endmodule

// ****************************************************************
// Load-once register
// ****************************************************************
// Set to RST_VAL by reset, loaded on the latch step, then frozen until the next reset
module obsc_hold_reg #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Load control
    input wire logic load,
    input wire logic [W-1:0] d,
    // Held value
    output logic [W-1:0] q
);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= RST_VAL;
        end else if (load) begin
            q <= d;
        end
    end

endmodule

// >>> hdl/obsc_pkg.sv
// Package for the start-up option loader: clock source codes, pin routing, timing.
// Assumes a single 20 MHz reference clock and a synchronous active-low reset.
package obsc_pkg;

    // ****************************************************************
    // Clock source selection
    // ****************************************************************
    typedef enum logic [1:0] {
        OBSC_SRC_INT_HS = 2'h0,
        OBSC_SRC_XTAL   = 2'h1,
        OBSC_SRC_EXT    = 2'h2
    } obsc_src_t;

    // ****************************************************************
    // Option word layout and reset values
    // ****************************************************************
    localparam int OBSC_OPT_W = 8;
    localparam int OBSC_SRC_LSB = 0;
    localparam int OBSC_WAIT_LSB = 2;
    localparam int OBSC_WAIT_W = 3;
    localparam logic [OBSC_OPT_W-1:0] OBSC_OPT_RST = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int OBSC_CLK_MHZ = 20;
    // Base unit of the stabilization wait, in microseconds
    localparam int OBSC_WAIT_UNIT_US = 16;
    localparam int OBSC_WAIT_UNIT_CYC = OBSC_WAIT_UNIT_US * OBSC_CLK_MHZ;
    // Cycles the non-volatile read takes before the option word is valid
    localparam int OBSC_READ_CYC = 4;
    localparam int OBSC_CNT_W = 24;

    // ****************************************************************
    // Grouped outputs
    // ****************************************************************
    typedef struct packed {
        logic pin_a_clock;
        logic pin_b_clock;
        logic port_a_en;
        logic port_b_en;
    } obsc_pins_t;

endpackage

// >>> verification/obsc_loader_assertions.sv
// Port checker for the start-up option loader.
// Assumes it is bound to obsc_loader with one clock and a synchronous reset.
`timescale 1ns/1ps
module obsc_checker #(
    parameter int WAIT_SCALE = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [obsc_pkg::OBSC_OPT_W-1:0] opt_data,
    input wire logic opt_read,
    input wire obsc_pkg::obsc_src_t clk_src,
    input wire obsc_pkg::obsc_pins_t pin_route,
    input wire logic cpu_reset_n,
    input wire logic opt_loaded
);
    // ****************************************************************
    // Source decode
    // ****************************************************************
    logic xt;
    logic ex;
    logic ih;
    assign xt = clk_src == obsc_pkg::OBSC_SRC_XTAL;
    assign ex = clk_src == obsc_pkg::OBSC_SRC_EXT;
    assign ih = clk_src == obsc_pkg::OBSC_SRC_INT_HS;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wait_xtal_a: assert property ($rose(opt_loaded) && xt |-> !cpu_reset_n [*2])
        else $error("crystal start ran no wait");
    no_wait_a: assert property ($rose(opt_loaded) && !xt |-> cpu_reset_n)
        else $error("start delayed without crystal");
    hold_read_a: assert property ($rose(rst_n) |-> !cpu_reset_n [*4])
        else $error("core ran before the option read");
    pins_xtal_a: assert property (opt_loaded && xt |-> pin_route == 4'hC)
        else $error("crystal pin routing wrong");
    pins_ext_a: assert property (opt_loaded && ex |-> pin_route == 4'h9)
        else $error("external clock pin routing wrong");
    pins_int_a: assert property (opt_loaded && ih |-> pin_route == 4'h3)
        else $error("internal source pin routing wrong");
    hold_sel_a: assert property (opt_loaded |=> opt_loaded && $stable(clk_src)
        && $stable(pin_route)) else $error("selection moved after load");
    load_time_a: assert property ($rose(rst_n) |-> ##3 !opt_loaded ##1 opt_loaded)
        else $error("option latch at wrong edge");
endmodule
bind obsc_loader obsc_checker #(.WAIT_SCALE(WAIT_SCALE)) i_chk (.ref_clk(ref_clk),
    .rst_n(rst_n), .opt_data(opt_data), .opt_read(opt_read), .clk_src(clk_src),
    .pin_route(pin_route), .cpu_reset_n(cpu_reset_n), .opt_loaded(opt_loaded));

// >>> verification/test_obsc_loader.sv
// Self-checking bench for the start-up option loader.
// Assumes a shortened wait scale; inputs change on the falling edge.
`timescale 1ns/1ps
module test_obsc_loader;
    localparam int SC = 2;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] opt_data = 8'h00;
    logic opt_read;
    logic cpu_reset_n;
    logic opt_loaded;
    obsc_pkg::obsc_src_t clk_src;
    obsc_pkg::obsc_pins_t pin_route;
    int bad_count = 0;
    int tests_run = 0;
    obsc_loader #(.WAIT_SCALE(SC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .opt_data(opt_data), .opt_read(opt_read), .clk_src(clk_src),
        .pin_route(pin_route), .cpu_reset_n(cpu_reset_n), .opt_loaded(opt_loaded));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Option changes after release so a late latch would show
    task automatic verify(input logic [7:0] opt, input logic [1:0] src, input logic [3:0] pins,
        input int cyc);
        int n;
        rst_n = 1'b0;
        opt_data = opt;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        n = 0;
        while (cpu_reset_n !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 600) begin
                bad_count++;
                print_verdict();
            end
        end
        opt_data = ~opt;
        check(n, cyc);
        repeat (3) @(negedge ref_clk);
        check(clk_src, src);
        check(pin_route, pins);
        check(opt_loaded, 1'b1);
        check(opt_read, 1'b0);
    endtask
    task automatic test_early_reset();
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(cpu_reset_n, 1'b0);
        check(opt_loaded, 1'b0);
        check(opt_read, 1'b1);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        verify(8'h00, 2'h0, 4'h3, 4);
        verify(8'h02, 2'h2, 4'h9, 4);
        verify(8'h03, 2'h3, 4'h3, 4);
        for (int k = 0; k < 8; k++) begin
            verify({3'h0, k[2:0], 2'h1}, 2'h1, 4'hC, 4 + (SC << k));
        end
        verify(8'h00, 2'h0, 4'h3, 4);
        test_early_reset();
        print_verdict();
    end
endmodule
